// file: src/gst_pkg.sv
/*
 gst_pkg: register offsets, field positions, reset values and timing
 constants of the gated 16-bit timer. Assumes a single 200 MHz clock
 and a plain register port with one-cycle read latency.
*/
// Summary of operation
// R1: 16-bit counter, byte access, writes load
// R2: on bit and gate enable control counting
// R3: clock select picks one of four sources
// R4: system clock gives four counts per instruction
// R5: external rising edges count, optionally synchronised
// R6: falling edge needed before first counted rise
// R7: prescaler divides by 1, 2, 4, 8
// R8: counter byte write clears prescaler
// R9: crystal oscillator enable, runs in sleep
// R10: software waits for oscillator stabilisation
// R11: sync disable bypasses synchroniser, sleep wakeup
// R12: sync mode switch may skip/add one
// R13: byte reads return a stable value
// R14: software stops counter before async writes
// R15: gated count only while gate matches polarity
// R16: gate source chosen from four, polarity applies
// R17: gate select codes pin, tmr8, cmp1, cmp2
// R18: rollover FFFF to 0000 sets sticky flag
// R19: reset clears counter, prescaler, flag; disabled
package gst_pkg;
   // ==========================================
   // register map
   localparam logic [3:0] ADDR_COUNT_LOW = 4'h0;
   localparam logic [3:0] ADDR_COUNT_HIGH = 4'h1;
   localparam logic [3:0] ADDR_CONTROL = 4'h2;
   localparam logic [3:0] ADDR_GATE = 4'h3;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_MASK = 4'h5;
   // ==========================================
   // counter_control fields
   localparam int CTL_ON = 0;
   localparam int CTL_SYNC_DIS = 2;
   localparam int CTL_OSC_EN = 3;
   localparam int CTL_PS_LO = 4;
   localparam int CTL_CS_LO = 6;
   localparam logic [7:0] CTL_WMASK = 8'hFD;
   // gate_control fields
   localparam int GCT_SS_LO = 0;
   localparam int GCT_POL = 6;
   localparam int GCT_EN = 7;
   localparam logic [7:0] GCT_WMASK = 8'hC3;
   // status fields
   localparam int STS_OVF = 0;
   // ==========================================
   // reset values and encodings
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] GCT_RESET = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   localparam logic [1:0] CS_INSTR = 2'h0;
   localparam logic [1:0] CS_SYS = 2'h1;
   localparam logic [1:0] CS_PIN = 2'h2;
   localparam logic [1:0] CS_SENSE = 2'h3;
   localparam logic [1:0] GS_PIN = 2'h0;
   localparam logic [1:0] GS_TMR8 = 2'h1;
   localparam logic [1:0] GS_CMP1 = 2'h2;
   localparam logic [1:0] GS_CMP2 = 2'h3;
   // ==========================================
   // timing: instruction clock is sys clock / 4
   localparam int CLK_MHZ = 200;
   localparam int INSTR_DIV = 4;
   localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);
endpackage

// file: src/gst_edge_sync.sv
/*
 gst_edge_sync: optional two-stage synchroniser and rising/falling
 edge detector for the external count input. Assumes the input is
 sampled on sys_clk_i; bypass picks the raw level.
*/
module gst_edge_sync
   import gst_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // input and control
   input wire logic level_i,
   input wire logic bypass_i,
   // edges and level
   output logic rise_o,
   output logic fall_o,
   output logic level_o
);
   logic meta;
   logic stage;
   logic prev;
   logic next_meta;
   logic next_stage;
   logic next_prev;
   logic chosen;

   // ==========================================
   // synchroniser; first stage read only by second
   always_comb begin
      next_meta = level_i;
      next_stage = meta;
      chosen = bypass_i ? level_i : stage; // R5 R11
      next_prev = chosen;
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         meta <= 1'b0;
         stage <= 1'b0;
         prev <= 1'b0;
      end else begin
         meta <= next_meta;
         stage <= next_stage;
         prev <= next_prev;
      end
   end

   // switching bypass shifts the seen edge by two cycles: one count may slip
   assign rise_o = chosen & ~prev; // R12
   assign fall_o = ~chosen & prev;
   assign level_o = chosen;

   sync_delay_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R5
      $rose(level_i) && !bypass_i ##1 !bypass_i [*2] |-> rise_o)
      else $error("synchronised edge late");
endmodule

// file: src/gst_timer.sv
/*
 gst_timer: gated 16-bit timer/counter with prescaler, four clock
 sources, gate selection, overflow interrupt. Assumes external, sense
 oscillator, crystal and gate inputs are synchronous-ish levels on
 sys_clk_i; the crystal itself is an external amplifier enabled here.
*/
// Decided for this implementation: the strobed register port and the address map.
module gst_timer
   import gst_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // register port
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // clock sources
   input wire logic ext_clock_pin_i,
   input wire logic crystal_in_pin_i,
   input wire logic sensing_osc_clock_i,
   // gate sources
   input wire logic gate_pin_i,
   input wire logic tmr8_overflow_i,
   input wire logic cmp1_out_i,
   input wire logic cmp2_out_i,
   // oscillator and interrupt
   output logic crystal_osc_enable_o,
   output logic irq_o
);
   logic [15:0] count;
   logic [2:0] prescale;
   logic [7:0] counter_control;
   logic [7:0] gate_control;
   logic overflow_flag;
   logic overflow_mask;
   logic [1:0] instr_div;
   logic armed;
   logic [7:0] rdata;
   logic [15:0] next_count;
   logic [2:0] next_prescale;
   logic [7:0] next_counter_control;
   logic [7:0] next_gate_control;
   logic next_overflow_flag;
   logic next_overflow_mask;
   logic [1:0] next_instr_div;
   logic next_armed;
   logic [7:0] next_rdata;
   logic ext_level;
   logic ext_rise;
   logic ext_fall;
   logic ext_now;
   logic instr_tick;
   logic src_tick;
   logic gate_sel;
   logic gate_ok;
   logic run;
   logic pre_tick;
   logic inc;
   logic wr_count;
   logic counter_on;
   logic gate_enable;
   logic sync_disable;
   logic [1:0] clock_select;
   logic [1:0] prescale_select;
   logic [1:0] gate_source_select;
   logic gate_polarity;

   function automatic logic [2:0] ps_limit(input logic [1:0] sel);
      ps_limit = 3'(({2'b00, 1'b1} << sel) - 3'h1);
   endfunction

   // ==========================================
   // field decode
   assign counter_on = counter_control[CTL_ON];
   assign sync_disable = counter_control[CTL_SYNC_DIS];
   assign crystal_osc_enable_o = counter_control[CTL_OSC_EN]; // R9
   assign prescale_select = counter_control[CTL_PS_LO +: 2];
   assign clock_select = counter_control[CTL_CS_LO +: 2];
   assign gate_source_select = gate_control[GCT_SS_LO +: 2];
   assign gate_polarity = gate_control[GCT_POL];
   assign gate_enable = gate_control[GCT_EN];
   assign wr_count = wr_i && (addr_i == ADDR_COUNT_LOW || addr_i == ADDR_COUNT_HIGH);

   // ==========================================
   // external source: pin or crystal, else sense oscillator
   assign ext_now = (clock_select == CS_SENSE) ? sensing_osc_clock_i :
                    (crystal_osc_enable_o ? crystal_in_pin_i : ext_clock_pin_i);

   gst_edge_sync u_sync (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .level_i(ext_now),
      .bypass_i(sync_disable), // R11
      .rise_o(ext_rise),
      .fall_o(ext_fall),
      .level_o(ext_level)
   );

   // ==========================================
   // source tick selection
   assign instr_tick = (instr_div == INSTR_LAST);
   always_comb begin
      case (clock_select)
         CS_INSTR: src_tick = instr_tick; // R3
         CS_SYS: src_tick = 1'b1; // R4
         CS_PIN: src_tick = ext_rise && armed; // R5 R6
         CS_SENSE: src_tick = ext_rise && armed; // R3
         default: src_tick = 1'b0;
      endcase
   end

   // ==========================================
   // gate
   always_comb begin
      case (gate_source_select)
         GS_PIN: gate_sel = gate_pin_i; // R17
         GS_TMR8: gate_sel = tmr8_overflow_i;
         GS_CMP1: gate_sel = cmp1_out_i;
         GS_CMP2: gate_sel = cmp2_out_i;
         default: gate_sel = 1'b0;
      endcase
   end
   assign gate_ok = (gate_sel == gate_polarity); // R15 R16
   assign run = counter_on && (!gate_enable || gate_ok); // R2
   assign pre_tick = run && src_tick;
   assign inc = pre_tick && (prescale == ps_limit(prescale_select)); // R7

   // ==========================================
   // counter, prescaler, edge arming
   always_comb begin
      next_count = count;
      next_prescale = prescale;
      next_armed = armed;
      next_instr_div = 2'(instr_div + 2'h1);
      if (pre_tick) begin
         next_prescale = inc ? 3'h0 : 3'(prescale + 3'h1);
      end
      if (inc) begin
         next_count = 16'(count + 16'h1);
      end
      // a lowered prescale must never leave the counter above its new limit
      if (wr_i && addr_i == ADDR_CONTROL && wdata_i[CTL_PS_LO +: 2] != prescale_select) begin
         next_prescale = 3'h0; // R7
      end
      // falling edge must be seen before a rise counts
      if (ext_fall) begin
         next_armed = 1'b1; // R6
      end
      if (!counter_on) begin
         next_armed = 1'b0; // R6
      end
      if (wr_count) begin
         next_prescale = 3'h0; // R8
         next_armed = 1'b0; // R6
         if (addr_i == ADDR_COUNT_LOW) begin
            next_count = {count[15:8], wdata_i}; // R1
         end else begin
            next_count = {wdata_i, count[7:0]}; // R1
         end
      end
   end

   // ==========================================
   // registers, flag and read data
   always_comb begin
      next_counter_control = counter_control;
      next_gate_control = gate_control;
      next_overflow_mask = overflow_mask;
      next_overflow_flag = overflow_flag;
      next_rdata = 8'h00;
      if (wr_i && addr_i == ADDR_CONTROL) begin
         next_counter_control = wdata_i & CTL_WMASK;
      end
      if (wr_i && addr_i == ADDR_GATE) begin
         next_gate_control = wdata_i & GCT_WMASK;
      end
      if (wr_i && addr_i == ADDR_MASK) begin
         next_overflow_mask = wdata_i[STS_OVF];
      end
      if (wr_i && addr_i == ADDR_STATUS && wdata_i[STS_OVF]) begin
         next_overflow_flag = 1'b0;
      end
      // set beats clear
      if (inc && count == COUNT_MAX && !wr_count) begin
         next_overflow_flag = 1'b1; // R18
      end
      if (rd_i) begin
         // reads come from the registered count, never mid-update
         case (addr_i)
            ADDR_COUNT_LOW: next_rdata = count[7:0]; // R13
            ADDR_COUNT_HIGH: next_rdata = count[15:8]; // R13
            ADDR_CONTROL: next_rdata = counter_control;
            ADDR_GATE: next_rdata = gate_control;
            ADDR_STATUS: next_rdata = {7'h00, overflow_flag};
            ADDR_MASK: next_rdata = {7'h00, overflow_mask};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         count <= COUNT_RESET; // R19
         prescale <= 3'h0;
         counter_control <= CTL_RESET;
         gate_control <= GCT_RESET;
         overflow_flag <= 1'b0;
         overflow_mask <= 1'b0;
         instr_div <= 2'h0;
         armed <= 1'b0;
         rdata <= 8'h00;
      end else begin
         count <= next_count;
         prescale <= next_prescale;
         counter_control <= next_counter_control;
         gate_control <= next_gate_control;
         overflow_flag <= next_overflow_flag;
         overflow_mask <= next_overflow_mask;
         instr_div <= next_instr_div;
         armed <= next_armed;
         rdata <= next_rdata;
      end
   end

   // level interrupt also serves as wake request in sleep
   assign irq_o = overflow_flag & overflow_mask; // R11
   assign rdata_o = rdata;

   // ==========================================
   // checks
   sequence s_wrap;
      inc && count == COUNT_MAX && !wr_count;
   endsequence

   sequence s_ext_edge;
      ext_rise && armed;
   endsequence

   sequence s_flag_clear;
      wr_i && addr_i == ADDR_STATUS && wdata_i[STS_OVF];
   endsequence

   // no falling edge seen on the pin for two cycles
   sequence s_unarmed_pin;
      (!ext_fall && clock_select == CS_PIN) [*2];
   endsequence

   off_hold_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R2
      !counter_on && !wr_count |=> $stable(count))
      else $error("count moved while off");

   gate_hold_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R15
      gate_enable && !gate_ok && !wr_count |=> $stable(count))
      else $error("gate ignored");

   sys_rate_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R4
      run && clock_select == CS_SYS && prescale_select == 2'h0 && !wr_count
      |=> count == 16'($past(count) + 16'h1)) else $error("sys clock no step");

   wrap_flag_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R18
      s_wrap |=> overflow_flag && count == 16'h0000)
      else $error("no overflow flag");

   write_load_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R1
      wr_i && addr_i == ADDR_COUNT_LOW |=> count[7:0] == $past(wdata_i) && prescale == 3'h0)
      else $error("low byte write lost");

   write_high_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R8
      wr_i && addr_i == ADDR_COUNT_HIGH |=> count[15:8] == $past(wdata_i) && prescale == 3'h0)
      else $error("high byte write lost");

   arm_needed_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R6
      wr_count ##1 s_unarmed_pin |-> $stable(count))
      else $error("count without falling edge");

   prescale_range_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R7
      prescale <= ps_limit(prescale_select) || $changed(prescale_select))
      else $error("prescale overrun");

   read_count_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R13
      rd_i && addr_i == ADDR_COUNT_LOW |=> rdata_o == $past(count[7:0]))
      else $error("bad count read");

   irq_clear_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R11
      s_flag_clear ##0 !inc |=> !irq_o)
      else $error("irq survived clear");

   gate_src_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R17
      gate_source_select == GS_CMP2 |-> gate_sel == cmp2_out_i)
      else $error("gate mux");

   instr_rate_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R3
      run && clock_select == CS_INSTR && !instr_tick && !wr_count |=> $stable(count))
      else $error("instruction clock too fast");

   ext_step_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R5
      run && clock_select == CS_PIN && prescale_select == 2'h0 && !wr_count ##0 s_ext_edge
      |=> count == 16'($past(count) + 16'h1)) else $error("pin edge not counted");

   flag_sticky_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R18
      overflow_flag && !(wr_i && addr_i == ADDR_STATUS && wdata_i[STS_OVF])
      |=> overflow_flag) else $error("flag dropped");

   reset_state_a: assert property (@(posedge sys_clk_i) // R19
      !resetn_i |=> count == COUNT_RESET && prescale == 3'h0 && !overflow_flag && !counter_on)
      else $error("reset left state");

   read_idle_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R13
      !rd_i |=> rdata_o == 8'h00) else $error("read data not idle");

   disarm_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R6
      !counter_on |=> !armed) else $error("armed while off");

   ps_change_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R7
      wr_i && addr_i == ADDR_CONTROL && wdata_i[CTL_PS_LO +: 2] != prescale_select
      |=> prescale == 3'h0) else $error("prescale kept on change");
endmodule

// file: testbench/gst_partner.sv
/*
 gst_partner: far-side count sources of the timer (pin, crystal, sense).
 Assumes bursts are requested on sys_clk_i; every line idles low.
*/
module gst_partner (
   // control
   input wire logic sys_clk_i,
   input wire logic go_i,
   input wire logic [1:0] sel_i,
   input wire logic [7:0] n_i,
   // lines
   output logic busy_o,
   output logic ext_clock_pin_o,
   output logic crystal_in_pin_o,
   output logic sensing_osc_clock_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic lvl;
   // ==========================================
   // burst of n rising edges, 8 cycles each
   initial begin
      busy_o = 1'b0;
      lvl = 1'b0;
      forever begin
         @(posedge sys_clk_i);
         if (go_i) begin
            busy_o <= 1'b1;
            repeat (n_i) begin
               repeat (4) @(posedge sys_clk_i);
               lvl <= 1'b1;
               repeat (4) @(posedge sys_clk_i);
               lvl <= 1'b0;
            end
            busy_o <= 1'b0;
         end
      end
   end
   // unselected lines stand still low
   assign ext_clock_pin_o = lvl & (sel_i == 2'h0);
   assign crystal_in_pin_o = lvl & (sel_i == 2'h1);
   assign sensing_osc_clock_o = lvl & (sel_i == 2'h2);
endmodule

// file: testbench/testbench.sv
/*
 testbench: self-checking run of gst_timer beside its source partner.
 Assumes the register map and field layout of gst_pkg.
*/
`define CHK(a,b) begin checked++; if ((a) !== (b)) begin num_errors++; \
$display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench
   import gst_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i, resetn_i, wr_i, rd_i, go, busy, ext, xtal, sense, osc_en, irq;
   logic [3:0] addr_i, gsrc;
   logic [7:0] wdata_i, rdata_o, n, r;
   logic [1:0] sel;
   logic [15:0] v;
   int num_errors, checked;
   // ==========================================
   // design and partner
   gst_timer u_dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .ext_clock_pin_i(ext), .crystal_in_pin_i(xtal), .sensing_osc_clock_i(sense),
      .gate_pin_i(gsrc[0]), .tmr8_overflow_i(gsrc[1]), .cmp1_out_i(gsrc[2]),
      .cmp2_out_i(gsrc[3]), .crystal_osc_enable_o(osc_en), .irq_o(irq));
   gst_partner u_far (.sys_clk_i(sys_clk_i), .go_i(go), .sel_i(sel), .n_i(n),
      .busy_o(busy), .ext_clock_pin_o(ext), .crystal_in_pin_o(xtal),
      .sensing_osc_clock_o(sense));
   initial begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end
   // ==========================================
   // bus helpers
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask
   task rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   task rd16(output logic [15:0] c);
      rd(ADDR_COUNT_LOW, c[7:0]);
      rd(ADDR_COUNT_HIGH, c[15:8]);
   endtask
   task clr;
      wr(ADDR_COUNT_LOW, 8'h00);
      wr(ADDR_COUNT_HIGH, 8'h00);
   endtask
   // counter stopped again before any later count write
   task run(input logic [7:0] c, input int cyc);
      wr(ADDR_CONTROL, c);
      repeat (cyc) @(posedge sys_clk_i);
      wr(ADDR_CONTROL, c & 8'hFE);
   endtask
   task near(input logic [15:0] c, input logic [15:0] e, input logic [15:0] t);
      `CHK(c + t >= e && c <= e + t, 1'b1)
   endtask
   task test_done;
      if (num_errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task burst(input logic [1:0] s, input logic [7:0] k);
      int i;
      @(posedge sys_clk_i);
      sel <= s;
      n <= k;
      go <= 1'b1;
      @(posedge sys_clk_i);
      go <= 1'b0;
      for (i = 0; i < 200; i++) begin
         @(posedge sys_clk_i);
         if (busy === 1'b0) break;
      end
      if (i == 200) begin
         num_errors++;
         test_done;
      end
   endtask
   // ==========================================
   // scenarios
   task t_reset;
      rd16(v);
      `CHK(v, COUNT_RESET)
      rd(ADDR_STATUS, r);
      `CHK(r, 8'h00)
      `CHK(irq, 1'b0)
      run({CS_SYS, 6'h00}, 20);
      rd16(v);
      `CHK(v, COUNT_RESET)
      wr(4'hF, 8'hAA);
      rd(4'hF, r);
      `CHK(r, 8'h00)
   endtask
   task t_bytes;
      wr(ADDR_COUNT_LOW, 8'h5A);
      wr(ADDR_COUNT_HIGH, 8'hC3);
      rd16(v);
      `CHK(v, 16'hC35A)
      wr(ADDR_GATE, 8'hFF);
      rd(ADDR_GATE, r);
      `CHK(r, GCT_WMASK)
      wr(ADDR_GATE, 8'h00);
   endtask
   task t_rate;
      int p;
      for (p = 0; p < 4; p++) begin
         clr;
         run({CS_SYS, 2'(p), 4'h1}, 64);
         rd16(v);
         near(v, 16'(65 >> p), 16'h3);
      end
      clr;
      run({CS_INSTR, 6'h01}, 64);
      rd16(v);
      near(v, 16'h10, 16'h2);
      run({CS_SYS, 6'h31}, 3);
      clr;
      run({CS_SYS, 6'h31}, 3);
      rd16(v);
      `CHK(v, 16'h0000)
   endtask
   task t_ext;
      int s;
      logic [7:0] c;
      for (s = 0; s < 3; s++) begin
         c = (s == 0) ? {CS_PIN, 6'h01} : (s == 1) ? {CS_PIN, 6'h0D} : {CS_SENSE, 6'h01};
         clr;
         wr(ADDR_CONTROL, c);
         #1;
         `CHK(osc_en, c[CTL_OSC_EN])
         burst(2'(s), 8'h0A);
         repeat (6) @(posedge sys_clk_i);
         wr(ADDR_CONTROL, 8'h00);
         rd16(v);
         `CHK(v, 16'h0009)
      end
   endtask
   task t_gate;
      int g;
      logic pol;
      for (g = 0; g < 4; g++) begin
         pol = g[0];
         wr(ADDR_GATE, {1'b1, pol, 4'h0, 2'(g)});
         gsrc <= {4{pol}} ^ (4'h1 << g);
         clr;
         run({CS_SYS, 6'h01}, 20);
         rd16(v);
         `CHK(v, 16'h0000)
         gsrc <= {4{pol}};
         clr;
         run({CS_SYS, 6'h01}, 20);
         rd16(v);
         near(v, 16'h0016, 16'h3);
      end
      wr(ADDR_GATE, 8'h00);
   endtask
   task t_ovf;
      wr(ADDR_COUNT_LOW, 8'hFF);
      wr(ADDR_COUNT_HIGH, 8'hFF);
      run({CS_SYS, 6'h01}, 4);
      rd(ADDR_STATUS, r);
      `CHK(r[STS_OVF], 1'b1)
      `CHK(irq, 1'b0)
      wr(ADDR_MASK, 8'h01);
      wr(ADDR_STATUS, 8'h00);
      @(posedge sys_clk_i);
      `CHK(irq, 1'b1)
      wr(ADDR_STATUS, 8'h01);
      @(posedge sys_clk_i);
      `CHK(irq, 1'b0)
      // stabilisation wait: preset, flag only after the full 1024 counts
      wr(ADDR_COUNT_LOW, 8'h00);
      wr(ADDR_COUNT_HIGH, 8'hFC);
      run({CS_SYS, 6'h09}, 1020);
      rd(ADDR_STATUS, r);
      `CHK(r[STS_OVF], 1'b0)
      run({CS_SYS, 6'h09}, 0);
      rd(ADDR_STATUS, r);
      `CHK(r[STS_OVF], 1'b1)
      `CHK(irq, 1'b1)
   endtask
   task t_midreset;
      wr(ADDR_COUNT_HIGH, 8'h12);
      wr(ADDR_CONTROL, {CS_SYS, 6'h31});
      @(posedge sys_clk_i);
      resetn_i <= 1'b0;
      repeat (6) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      rd16(v);
      `CHK(v, COUNT_RESET)
      rd(ADDR_CONTROL, r);
      `CHK(r, CTL_RESET)
      rd(ADDR_STATUS, r);
      `CHK(r, 8'h00)
      `CHK(irq, 1'b0)
   endtask
   // ==========================================
   // main sequence
   initial begin
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 4'h0;
      wdata_i = 8'h00;
      gsrc = 4'h0;
      go = 1'b0;
      n = 8'h00;
      sel = 2'h0;
      resetn_i = 1'b0;
      num_errors = 0;
      checked = 0;
      repeat (6) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      t_reset;
      t_bytes;
      t_rate;
      t_ext;
      t_gate;
      t_ovf;
      t_midreset;
      test_done;
   end
endmodule
